// ### logic/csa_top.sv
// Two-socket card access block with its Avalon-MM register slave.
// Assumes card pins are asynchronous; pads resolve data bus from the enable.
//
// How it works
// - Each socket drives a 26-bit card address covering 64M bytes.
// - Data bus has out, in and enable; driven only for writes.
// - Two active-low byte enables with address bit zero pick width and lane.
// - Width comes from control bit, or card width pin in I/O cycles.
// - Space select low means attribute memory, high means common memory.
// - I/O access is refused while socket is in common memory mode.
// - I/O write strobe pulses low only with space select low.
// - I/O read strobe pulses low only with space select low.
// - Memory write strobe writes common or attribute memory per space select.
// - Memory output enable gates read data from the selected space.
// - Card reset output is active high and follows a control bit.
// - Both voltage sense pins are synchronised and readable in status.
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module csa_top import csa_pkg::*; #(
    parameter int NUM_SOCKETS = CSA_NUM_SOCKETS,
    parameter int SETUP_CYCLES = CSA_SETUP_CYC,
    parameter int STROBE_CYCLES = CSA_STROBE_CYC,
    parameter int HOLD_CYCLES = CSA_HOLD_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire csa_card_in_t [1:0] card_in,
    output csa_card_out_t [1:0] card_out
);

    // Per-socket software state
    logic [2:0] ctrl_reg [NUM_SOCKETS];
    logic [25:0] addr_reg [NUM_SOCKETS];
    logic [15:0] wdata_reg [NUM_SOCKETS];
    logic refused_reg [NUM_SOCKETS];
    logic done_reg [NUM_SOCKETS];

    // Synchroniser stages for card inputs
    csa_card_in_t sync1_reg [NUM_SOCKETS];
    csa_card_in_t sync2_reg [NUM_SOCKETS];

    // Socket results
    logic busy [NUM_SOCKETS];
    logic done_pulse [NUM_SOCKETS];
    logic refused_pulse [NUM_SOCKETS];
    logic io16 [NUM_SOCKETS];
    logic [15:0] rdata [NUM_SOCKETS];
    logic start [NUM_SOCKETS];

    // Bus decode
    logic sock_sel;
    logic [4:0] local_off;
    logic in_range;
    logic rd_done_reg;
    logic cmd_stall;
    logic wr_take;
    logic [31:0] rd_word;

    // Merge written bytes into an old value
    function automatic logic [31:0] apply_be(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        apply_be = res;
    endfunction

    // Hit test for one socket and one offset
    function automatic logic reg_hit(input logic sel,
                                     input logic [4:0] off,
                                     input int sock,
                                     input logic [4:0] target);
        reg_hit = (sel == 1'(sock)) && (off == target);
    endfunction

    // Address split: bit 5 picks the socket, bits 7:6 must be zero
    assign sock_sel = avs_address_in[5];
    assign local_off = avs_address_in[4:0];
    assign in_range = (avs_address_in[7:6] == CSA_AV_TOP_ZERO);

    // Command write waits while the addressed socket is busy
    assign cmd_stall = avs_write_in && in_range && (local_off == CSA_OFF_CMD) && busy[sock_sel];

    // Waitrequest: frozen clock, first read cycle, busy socket
    assign avs_waitrequest_out = !ce_in || (avs_read_in && !rd_done_reg) || cmd_stall;
    assign wr_take = ce_in && avs_write_in && !avs_waitrequest_out && in_range;

    // Read answer one cycle after the request
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_done_reg <= 1'b0;
        end else if (ce_in) begin
            rd_done_reg <= avs_read_in && !rd_done_reg;
        end
    end

    // Read multiplexer, unmapped offsets read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (in_range) begin
            unique case (local_off)
                CSA_OFF_CTRL: begin
                    rd_word = {29'h0000_0000, ctrl_reg[sock_sel]};
                end
                CSA_OFF_ADDR: begin
                    rd_word = {6'h00, addr_reg[sock_sel]};
                end
                CSA_OFF_WDATA: begin
                    rd_word = {16'h0000, wdata_reg[sock_sel]};
                end
                CSA_OFF_RDATA: begin
                    rd_word = {16'h0000, rdata[sock_sel]};
                end
                CSA_OFF_STATUS: begin
                    rd_word[CSA_STAT_BUSY_BIT] = busy[sock_sel];
                    rd_word[CSA_STAT_VS_LO_BIT] = sync2_reg[sock_sel].voltage_sense_lo;
                    rd_word[CSA_STAT_VS_HI_BIT] = sync2_reg[sock_sel].voltage_sense_hi;
                    rd_word[CSA_STAT_IO16_BIT] = io16[sock_sel];
                    rd_word[CSA_STAT_REFUSED_BIT] = refused_reg[sock_sel];
                    rd_word[CSA_STAT_DONE_BIT] = done_reg[sock_sel];
                end
                default: begin
                    rd_word = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data register, loaded in the waiting cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (ce_in && avs_read_in && !rd_done_reg) begin
            avs_readdata_out <= rd_word;
        end
    end

    genvar s;
    generate
        for (s = 0; s < NUM_SOCKETS; s++) begin : g_sock
            logic [31:0] ctrl_wide;
            logic [31:0] addr_wide;
            logic [31:0] wdata_wide;
            logic hit_ctrl;
            logic hit_addr;
            logic hit_wdata;
            logic hit_cmd;
            logic hit_status;

            assign hit_ctrl = wr_take && reg_hit(sock_sel, local_off, s, CSA_OFF_CTRL);
            assign hit_addr = wr_take && reg_hit(sock_sel, local_off, s, CSA_OFF_ADDR);
            assign hit_wdata = wr_take && reg_hit(sock_sel, local_off, s, CSA_OFF_WDATA);
            assign hit_cmd = wr_take && reg_hit(sock_sel, local_off, s, CSA_OFF_CMD);
            assign hit_status = wr_take && reg_hit(sock_sel, local_off, s, CSA_OFF_STATUS);
            assign ctrl_wide = apply_be({29'h0000_0000, ctrl_reg[s]}, avs_writedata_in, avs_byteenable_in);
            assign addr_wide = apply_be({6'h00, addr_reg[s]}, avs_writedata_in, avs_byteenable_in);
            assign wdata_wide = apply_be({16'h0000, wdata_reg[s]}, avs_writedata_in, avs_byteenable_in);

            // Start pulse from a command write with the low byte enabled
            assign start[s] = hit_cmd && avs_byteenable_in[0];

            // Two-flop synchroniser on every card input
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    sync1_reg[s] <= '1;
                    sync2_reg[s] <= '1;
                end else if (ce_in) begin
                    sync1_reg[s] <= card_in[s];
                    sync2_reg[s] <= sync1_reg[s];
                end
            end

            // Control, address and write data registers
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    ctrl_reg[s] <= CSA_CTRL_RESET_VAL;
                    addr_reg[s] <= CSA_ADDR_RESET_VAL;
                    wdata_reg[s] <= CSA_DATA_RESET_VAL;
                end else if (ce_in) begin
                    if (hit_ctrl) begin
                        ctrl_reg[s] <= ctrl_wide[2:0];
                    end
                    if (hit_addr) begin
                        addr_reg[s] <= addr_wide[25:0];
                    end
                    if (hit_wdata) begin
                        wdata_reg[s] <= wdata_wide[15:0];
                    end
                end
            end

            // Sticky refused and done flags, set wins over write-one clear
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    refused_reg[s] <= 1'b0;
                    done_reg[s] <= 1'b0;
                end else if (ce_in) begin
                    if (refused_pulse[s]) begin
                        refused_reg[s] <= 1'b1;
                    end else if (hit_status && avs_byteenable_in[0] && avs_writedata_in[CSA_STAT_REFUSED_BIT]) begin
                        refused_reg[s] <= 1'b0;
                    end
                    if (done_pulse[s]) begin
                        done_reg[s] <= 1'b1;
                    end else if (hit_status && avs_byteenable_in[0] && avs_writedata_in[CSA_STAT_DONE_BIT]) begin
                        done_reg[s] <= 1'b0;
                    end
                end
            end

            // One identical sequencer per socket
            csa_socket #(
                .SETUP_CYCLES(SETUP_CYCLES),
                .STROBE_CYCLES(STROBE_CYCLES),
                .HOLD_CYCLES(HOLD_CYCLES)
            ) u_socket (
                .clk_in,
                .rst_n_in,
                .ce_in,
                .start_in(start[s]),
                .cmd_in(csa_cmd_t'(avs_writedata_in[1:0])),
                .addr_in(addr_reg[s]),
                .wdata_in(wdata_reg[s]),
                .width16_in(ctrl_reg[s][CSA_CTRL_WIDTH16_BIT]),
                .attr_in(ctrl_reg[s][CSA_CTRL_ATTR_BIT]),
                .card_reset_in(ctrl_reg[s][CSA_CTRL_RESET_BIT]),
                .pins_in(sync2_reg[s]),
                .busy_out(busy[s]),
                .done_out(done_pulse[s]),
                .refused_out(refused_pulse[s]),
                .io16_out(io16[s]),
                .rdata_out(rdata[s]),
                .pins_out(card_out[s])
            );
        end
    endgenerate

endmodule

// ### logic/csa_pkg.sv
// Shared constants, types and helpers for the card socket access block.
// Assumes one 40 MHz clock and a 32-bit Avalon-MM register port.
package csa_pkg;

    // Socket count and bus widths
    localparam int CSA_NUM_SOCKETS = 2;
    localparam int CSA_CARD_ADDR_W = 26;
    localparam int CSA_CARD_DATA_W = 16;
    localparam int CSA_AV_ADDR_W = 8;

    // Register map: one 32-byte window per socket
    localparam logic [1:0] CSA_AV_TOP_ZERO = 2'h0;
    localparam logic [4:0] CSA_OFF_CTRL = 5'h00;
    localparam logic [4:0] CSA_OFF_ADDR = 5'h04;
    localparam logic [4:0] CSA_OFF_WDATA = 5'h08;
    localparam logic [4:0] CSA_OFF_CMD = 5'h0C;
    localparam logic [4:0] CSA_OFF_RDATA = 5'h10;
    localparam logic [4:0] CSA_OFF_STATUS = 5'h14;

    // Control register fields and reset value
    localparam int CSA_CTRL_RESET_BIT = 0;
    localparam int CSA_CTRL_WIDTH16_BIT = 1;
    localparam int CSA_CTRL_ATTR_BIT = 2;
    localparam logic [2:0] CSA_CTRL_RESET_VAL = 3'h1;

    // Status register fields
    localparam int CSA_STAT_BUSY_BIT = 0;
    localparam int CSA_STAT_VS_LO_BIT = 1;
    localparam int CSA_STAT_VS_HI_BIT = 2;
    localparam int CSA_STAT_IO16_BIT = 3;
    localparam int CSA_STAT_REFUSED_BIT = 4;
    localparam int CSA_STAT_DONE_BIT = 5;

    // Reset values of data holding registers
    localparam logic [25:0] CSA_ADDR_RESET_VAL = 26'h000_0000;
    localparam logic [15:0] CSA_DATA_RESET_VAL = 16'h0000;

    // Cycle timing: figures in ns, counts rounded up
    localparam int CSA_CLK_PERIOD_NS = 25;
    localparam int CSA_SETUP_NS = 100;
    localparam int CSA_STROBE_NS = 150;
    localparam int CSA_HOLD_NS = 35;
    localparam int CSA_SETUP_CYC = (CSA_SETUP_NS + CSA_CLK_PERIOD_NS - 1) / CSA_CLK_PERIOD_NS;
    localparam int CSA_STROBE_CYC = (CSA_STROBE_NS + CSA_CLK_PERIOD_NS - 1) / CSA_CLK_PERIOD_NS;
    localparam int CSA_HOLD_CYC = (CSA_HOLD_NS + CSA_CLK_PERIOD_NS - 1) / CSA_CLK_PERIOD_NS;

    // Access commands
    typedef enum logic [1:0] {
        CSA_CMD_MEM_RD = 2'h0,
        CSA_CMD_MEM_WR = 2'h1,
        CSA_CMD_IO_RD = 2'h2,
        CSA_CMD_IO_WR = 2'h3
    } csa_cmd_t;

    // Access sequencer states
    typedef enum logic [3:0] {
        CSA_ST_IDLE = 4'h1,
        CSA_ST_SETUP = 4'h2,
        CSA_ST_STROBE = 4'h4,
        CSA_ST_HOLD = 4'h8
    } csa_state_t;

    // Signals driven toward one card
    typedef struct packed {
        logic [25:0] card_addr;
        logic [15:0] card_data_out;
        logic card_data_oe;
        logic low_byte_enable_n;
        logic high_byte_enable_n;
        logic space_sel_n;
        logic mem_write_strobe_n;
        logic mem_output_enable_n;
        logic io_write_strobe_n;
        logic io_read_strobe_n;
        logic card_reset;
    } csa_card_out_t;

    // Signals arriving from one card
    typedef struct packed {
        logic [15:0] card_data_in;
        logic io_width16_n;
        logic voltage_sense_hi;
        logic voltage_sense_lo;
    } csa_card_in_t;

    // True for I/O space commands
    function automatic logic csa_is_io(input csa_cmd_t cmd);
        csa_is_io = (cmd == CSA_CMD_IO_RD) || (cmd == CSA_CMD_IO_WR);
    endfunction

    // True for commands that drive data to the card
    function automatic logic csa_is_write(input csa_cmd_t cmd);
        csa_is_write = (cmd == CSA_CMD_MEM_WR) || (cmd == CSA_CMD_IO_WR);
    endfunction

endpackage

// ### logic/csa_socket.sv
// One socket's access sequencer and registered card-side signals.
// Assumes card inputs arrive already synchronised to clk_in.
`timescale 1ns/1ps
module csa_socket import csa_pkg::*; #(
    parameter int SETUP_CYCLES = CSA_SETUP_CYC,
    parameter int STROBE_CYCLES = CSA_STROBE_CYC,
    parameter int HOLD_CYCLES = CSA_HOLD_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic start_in,
    input wire csa_cmd_t cmd_in,
    input wire logic [25:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic width16_in,
    input wire logic attr_in,
    input wire logic card_reset_in,
    input wire csa_card_in_t pins_in,
    output logic busy_out,
    output logic done_out,
    output logic refused_out,
    output logic io16_out,
    output logic [15:0] rdata_out,
    output csa_card_out_t pins_out
);

    csa_state_t state_reg;
    logic [7:0] cnt_reg;
    csa_cmd_t cmd_reg;
    logic [25:0] addr_reg;
    logic [15:0] wdata_reg;
    logic wide16_reg;
    logic attr_reg;
    logic accept;
    logic active;
    logic wide;
    logic last_cycle;

    // I/O refused while socket sits in common memory mode
    assign refused_out = start_in && csa_is_io(cmd_in) && !attr_in;
    assign accept = start_in && !refused_out && (state_reg == CSA_ST_IDLE);
    assign busy_out = (state_reg != CSA_ST_IDLE);
    assign active = busy_out;
    // I/O width from the card, memory width from software
    assign wide = csa_is_io(cmd_reg) ? !pins_in.io_width16_n : wide16_reg;
    assign last_cycle = (state_reg == CSA_ST_STROBE) && (cnt_reg == 8'(STROBE_CYCLES - 1));

    // Sequencer: one phase at a time, so one strobe at most
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= CSA_ST_IDLE;
            cnt_reg <= 8'h00;
        end else if (ce_in) begin
            unique case (state_reg)
                CSA_ST_IDLE: begin
                    cnt_reg <= 8'h00;
                    if (accept) begin
                        state_reg <= CSA_ST_SETUP;
                    end
                end
                CSA_ST_SETUP: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == 8'(SETUP_CYCLES - 1)) begin
                        state_reg <= CSA_ST_STROBE;
                        cnt_reg <= 8'h00;
                    end
                end
                CSA_ST_STROBE: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (last_cycle) begin
                        state_reg <= CSA_ST_HOLD;
                        cnt_reg <= 8'h00;
                    end
                end
                CSA_ST_HOLD: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == 8'(HOLD_CYCLES - 1)) begin
                        state_reg <= CSA_ST_IDLE;
                        cnt_reg <= 8'h00;
                    end
                end
            endcase
        end
    end

    // Completion pulse at the end of the hold phase
    assign done_out = ce_in && (state_reg == CSA_ST_HOLD) && (cnt_reg == 8'(HOLD_CYCLES - 1));

    // Access parameters latched at start
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cmd_reg <= CSA_CMD_MEM_RD;
            addr_reg <= CSA_ADDR_RESET_VAL;
            wdata_reg <= CSA_DATA_RESET_VAL;
            wide16_reg <= 1'b0;
            attr_reg <= 1'b0;
        end else if (ce_in && accept) begin
            cmd_reg <= cmd_in;
            addr_reg <= addr_in;
            wdata_reg <= wdata_in;
            wide16_reg <= width16_in;
            attr_reg <= attr_in;
        end
    end

    // Read data and width capture on the last strobe cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= CSA_DATA_RESET_VAL;
            io16_out <= 1'b0;
        end else if (ce_in && last_cycle && !csa_is_write(cmd_reg)) begin
            rdata_out <= wide ? pins_in.card_data_in : {8'h00, pins_in.card_data_in[7:0]};
            io16_out <= csa_is_io(cmd_reg) && wide;
        end
    end

    // Registered card-side outputs
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pins_out <= {CSA_ADDR_RESET_VAL, CSA_DATA_RESET_VAL, 1'b0, 8'hFF}; // Idle pins, card held in reset
        end else if (ce_in) begin
            pins_out.card_addr <= {addr_reg[25:1], addr_reg[0] && !wide};
            pins_out.card_data_out <= wide ? wdata_reg : {8'h00, wdata_reg[7:0]};
            pins_out.card_data_oe <= active && csa_is_write(cmd_reg);
            pins_out.low_byte_enable_n <= !active;
            pins_out.high_byte_enable_n <= !(active && wide);
            pins_out.space_sel_n <= !(active && attr_reg);
            pins_out.mem_write_strobe_n <= !((state_reg == CSA_ST_STROBE) && (cmd_reg == CSA_CMD_MEM_WR));
            pins_out.mem_output_enable_n <= !((state_reg == CSA_ST_STROBE) && (cmd_reg == CSA_CMD_MEM_RD));
            pins_out.io_write_strobe_n <= !((state_reg == CSA_ST_STROBE) && (cmd_reg == CSA_CMD_IO_WR) && attr_reg);
            pins_out.io_read_strobe_n <= !((state_reg == CSA_ST_STROBE) && (cmd_reg == CSA_CMD_IO_RD) && attr_reg);
            pins_out.card_reset <= card_reset_in;
        end
    end

endmodule

// ### bench/csa_top_chk.sv
// Checker for card-side strobe, lane and space relations.
// Assumes a bind onto csa_top; sees its card pins only.
`timescale 1ns/1ps
module csa_top_chk import csa_pkg::*; #(
    parameter int STROBE_CYCLES = CSA_STROBE_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire csa_card_out_t [1:0] card_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    csa_card_out_t c0;
    logic [3:0] st;
    int n;
    // Socket 0 strobes, all active low
    assign c0 = card_out[0];
    assign st = {c0.mem_write_strobe_n, c0.mem_output_enable_n, c0.io_write_strobe_n, c0.io_read_strobe_n};
    // Cycles the current strobe has been low
    always_ff @(posedge clk_in) begin
        n <= (!rst_n_in || &st) ? 0 : n + 1;
    end
    chk_iow_attr: assert property (!c0.io_write_strobe_n |-> !c0.space_sel_n)
        else $error("io write in common mode");
    chk_ior_attr: assert property (!card_out[1].io_read_strobe_n |-> !card_out[1].space_sel_n)
        else $error("io read in common mode");
    chk_one_strobe: assert property ($onehot0(~st))
        else $error("two strobes low");
    chk_strobe_len: assert property ($rose(&st) |-> n == STROBE_CYCLES)
        else $error("strobe length wrong");
    chk_wr_drive: assert property (!c0.mem_write_strobe_n |-> c0.card_data_oe)
        else $error("write without data drive");
    chk_rd_release: assert property (!st[2] |-> !c0.card_data_oe)
        else $error("data driven during read");
    chk_wide_lane: assert property (!c0.high_byte_enable_n |-> !c0.low_byte_enable_n && !c0.card_addr[0])
        else $error("bad wide lane");
    chk_enable_setup: assert property ($fell(&st) |-> $past(c0.low_byte_enable_n) == 1'b0)
        else $error("enable not set up");
    chk_space_hold: assert property (!(&st) |=> $stable(c0.space_sel_n) || &st)
        else $error("space select moved");
    cov_io_wr: cover property ($fell(c0.io_write_strobe_n));
    cov_io_rd: cover property ($fell(card_out[1].io_read_strobe_n));
    cov_mem_wr: cover property ($fell(c0.mem_write_strobe_n));
endmodule
bind csa_top csa_top_chk #(.STROBE_CYCLES(STROBE_CYCLES)) u_chk (.clk_in, .rst_n_in, .card_out);

// ### bench/csa_card_model.sv
// Card model: byte stores for attribute, common and I/O space.
// Assumes registered csa_top pins; 256-byte window per space.
`timescale 1ns/1ps
module csa_card_model import csa_pkg::*; (
    input wire logic clk_in,
    input wire csa_card_out_t pins_in,
    input wire logic io16_n_in,
    input wire logic [1:0] vs_in,
    output csa_card_in_t pins_out
);
    logic [7:0] mem [0:767];
    logic [15:0] last, d;
    logic [9:0] a;
    logic io, wide;
    // Space from strobe kind and space select
    assign io = !pins_in.io_write_strobe_n || !pins_in.io_read_strobe_n;
    assign wide = !pins_in.high_byte_enable_n;
    assign a = (io ? 10'h200 : pins_in.space_sel_n ? 10'h100 : 10'h000) + {2'h0, pins_in.card_addr[7:0]};
    // Read data; a released bus toggles every cycle
    assign d = (!pins_in.mem_output_enable_n || !pins_in.io_read_strobe_n)
        ? {wide ? mem[a + 10'h1] : ~last[15:8], mem[a]} : ~last;
    assign pins_out = {d, io16_n_in, vs_in};
    // Store written bytes, remember bus value
    always @(posedge clk_in) begin
        last <= d;
        if (!pins_in.mem_write_strobe_n || !pins_in.io_write_strobe_n) begin
            mem[a] <= pins_in.card_data_out[7:0];
            if (wide) begin
                mem[a + 10'h1] <= pins_in.card_data_out[15:8];
            end
        end
    end
    initial begin
        last = 16'h0000;
        for (int i = 0; i < 768; i++) begin
            mem[i] = 8'h00;
        end
    end
endmodule

// ### bench/csa_top_tb.sv
// Bench: register traffic, card accesses on both sockets, reference byte store.
// Assumes csa_top with short timing and two card models.
`timescale 1ns/1ps
module csa_top_tb import csa_pkg::*; ;
    localparam int STB = 4;
    logic clk_in, rst_n_in, ce_in, avs_read_in, avs_write_in, avs_waitrequest_out, io, at, w;
    logic [7:0] avs_address_in;
    logic [25:0] ad;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    logic [3:0] avs_byteenable_in, vs;
    logic [1:0] io16_n;
    csa_card_in_t [1:0] card_in;
    csa_card_out_t [1:0] card_out;
    csa_card_out_t cap [0:1];
    logic [7:0] ref_mem [0:1535];
    int fails, n_tests, n_low [0:1];
    csa_top #(.SETUP_CYCLES(1), .STROBE_CYCLES(STB), .HOLD_CYCLES(1)) DUT (.clk_in, .rst_n_in, .ce_in,
        .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
        .avs_waitrequest_out, .card_in, .card_out);
    csa_card_model card_a (.clk_in, .pins_in(card_out[0]), .io16_n_in(io16_n[0]), .vs_in(vs[1:0]),
        .pins_out(card_in[0]));
    csa_card_model card_b (.clk_in, .pins_in(card_out[1]), .io16_n_in(io16_n[1]), .vs_in(vs[3:2]),
        .pins_out(card_in[1]));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    function automatic logic [3:0] strb(input csa_card_out_t p);
        return {p.mem_write_strobe_n, p.mem_output_enable_n, p.io_write_strobe_n, p.io_read_strobe_n};
    endfunction
    // Count strobe-low cycles and snapshot the pins
    always @(posedge clk_in) begin
        for (int s = 0; s < 2; s++) begin
            if (!(&strb(card_out[s]))) begin
                n_low[s] <= n_low[s] + 1;
                cap[s] <= card_out[s];
            end
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One Avalon transfer; read data lands in q
    task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    // One card access checked against the reference store
    task automatic access(input int s, input logic [1:0] cmd, input logic [25:0] ad, input logic at, input logic w);
        logic [7:0] b;
        logic [15:0] wd;
        logic wide, bad;
        int k, n0;
        b = {2'h0, s[0], 5'h00};
        wd = 16'($urandom);
        io16_n[s] <= 1'($urandom);
        bad = cmd[1] && !at;
        n0 = n_low[s];
        av(1'b1, b | CSA_OFF_CTRL, {29'h0, at, w, 1'b0});
        av(1'b1, b | CSA_OFF_ADDR, {6'h00, ad});
        av(1'b1, b | CSA_OFF_WDATA, {16'h0000, wd});
        av(1'b1, b | CSA_OFF_CMD, {30'h0, cmd});
        do av(1'b0, b | CSA_OFF_STATUS, 32'h0); while (q[0] !== 1'b0);
        wide = cmd[1] ? !io16_n[s] : w;
        k = s * 768 + (cmd[1] ? 512 : at ? 0 : 256) + (wide ? {ad[7:1], 1'b0} : ad[7:0]);
        check(q[2:1], vs[s * 2 +: 2]);
        check(n_low[s] - n0, bad ? 0 : STB);
        check(card_out[s].card_reset, 1'b0);
        check(q[5:4], bad ? 2'h1 : 2'h2);
        if (!bad) begin
            check(cap[s].card_addr, wide ? {ad[25:1], 1'b0} : ad);
            check(cap[s].space_sel_n, !at);
            check(cap[s].high_byte_enable_n, !wide);
            check(strb(cap[s]), 4'hF ^ (4'h1 << {!cmd[1], cmd[0]}));
            if (cmd[0]) begin
                ref_mem[k] = wd[7:0];
                if (wide) ref_mem[k + 1] = wd[15:8];
                check(cap[s].card_data_out, wide ? wd : {8'h00, wd[7:0]});
            end else begin
                if (cmd[1]) check(q[3], wide);
                av(1'b0, b | CSA_OFF_RDATA, 32'h0);
                check(q, {16'h0, wide ? ref_mem[k + 1] : 8'h00, ref_mem[k]});
            end
        end
        av(1'b1, b | CSA_OFF_STATUS, bad ? 32'h0000_0010 : 32'h0000_0020);
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        fails++;
        results();
    end
    initial begin
        {rst_n_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
        ce_in = 1'b1;
        avs_byteenable_in = 4'hF;
        io16_n = 2'h3;
        {fails, n_tests, n_low[0], n_low[1]} = '0;
        for (int i = 0; i < 1536; i++) ref_mem[i] = 8'h00;
        void'($urandom(84));
        vs = 4'($urandom);
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        check(card_out[0].card_reset, 1'b1);
        check(card_out[1].card_reset, 1'b1);
        for (int i = 0; i < 24; i++) begin
            vs <= 4'($urandom);
            {ad, io, at, w} = 29'($urandom);
            at = at | io;
            access(i % 2, {io, 1'b1}, ad, at, w);
            access(i % 2, {io, 1'b0}, ad, at, w);
        end
        access(0, CSA_CMD_IO_WR, ad, 1'b0, 1'b1);
        access(1, CSA_CMD_IO_RD, ad, 1'b0, 1'b0);
        // Unmapped place and command register read as zero
        av(1'b1, 8'hC0, 32'hFFFF_FFFF);
        av(1'b0, 8'hC0, 32'h0);
        check(q, 32'h0);
        av(1'b0, 8'h2C, 32'h0);
        check(q, 32'h0);
        // Card reset raised on socket 1 only
        av(1'b1, 8'h20, 32'h0000_0001);
        av(1'b0, 8'h20, 32'h0);
        check(q, 32'h0000_0001);
        check(card_out[1].card_reset, 1'b1);
        check(card_out[0].card_reset, 1'b0);
        results();
    end
endmodule
